// ### sar_pkg.sv
// sar_pkg: constants and carrier types of the serial converter reader.
// assumes a 20 MHz system clock and a byte-addressed 32-bit register port.
package sar_pkg;

  // ----------------------------------------------------------------
  // clock and frame
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned FRAME_BITS = 20;
  localparam int unsigned RES_BITS   = 16;
  // result field of the received word: the first 16 bits shifted in
  localparam int unsigned RES_LSB    = FRAME_BITS - RES_BITS;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DIV   = 8'h04;
  localparam logic [7:0] OFS_PER   = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0c;
  localparam logic [7:0] OFS_RADDR = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam logic [7:0] OFS_LAST  = 8'h18;

  // ----------------------------------------------------------------
  // field positions, reset values and divider minimum
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_FLUSH = 1;
  localparam int unsigned CTRL_HOLD  = 2;
  localparam int unsigned STAT_OVF   = 11;
  localparam int unsigned STAT_LVL   = 16;
  localparam int unsigned STAT_WRAP  = 24;
  localparam logic [7:0] DIV_RST     = 8'h10;
  localparam logic [7:0] PER_RST     = 8'h14;
  localparam logic [7:0] DIV_MIN     = 8'h02;

  typedef enum logic {
    SAR_IDLE = 1'b0,
    SAR_RUN  = 1'b1
  } sar_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sar_bus_req_t;

endpackage

// ### sar_reader.sv
// sar_reader: serial receive port that drives a serial converter and
// fills a circular sample buffer, plus its elastic fifo.
// assumes one 20 MHz clock; receive_data_in is an asynchronous pin.
`timescale 1ns/100ps

// ------------------------------------------------------------------
// elastic fifo
// ------------------------------------------------------------------
module sar_fifo #(
  parameter int unsigned W = 20,
  parameter int unsigned D = 16,
  parameter int unsigned AW = $clog2(D)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          flush,
  input  wire logic          in_valid,
  output      logic          in_ready,
  input  wire logic [W-1:0]  in_data,
  output      logic          out_valid,
  input  wire logic          out_ready,
  output      logic [W-1:0]  out_data,
  output      logic [AW:0]   level
);
  logic [W-1:0] mem_reg [D];
  logic [AW:0]  wp_reg;
  logic [AW:0]  rp_reg;
  wire          do_push = in_valid && in_ready;
  wire          do_pop  = out_valid && out_ready;

  assign level     = wp_reg - rp_reg;
  assign in_ready  = (level != (AW+1)'(D));
  assign out_valid = (level != '0);
  assign out_data  = mem_reg[rp_reg[AW-1:0]];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (do_push)
        wp_reg <= wp_reg + 1'b1;
      if (do_pop)
        rp_reg <= rp_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push)
      mem_reg[wp_reg[AW-1:0]] <= in_data;
  end

  fifo_bound_a: assert property (
    @(posedge clk) disable iff (rst)
    !in_ready && !out_ready && !flush |=> !in_ready && level != '0)
    else $error("fifo went beyond its depth");
endmodule

// ------------------------------------------------------------------
// reader top
// ------------------------------------------------------------------
module sar_reader #(
  parameter int unsigned BUF_DEPTH  = 1024,
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned IW = $clog2(BUF_DEPTH)
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire sar_pkg::sar_bus_req_t bus_req,
  output      logic [31:0]           bus_rdata,
  output      logic                  serial_clock_out,
  output      logic                  frame_sync_out,
  output      logic                  conversion_trigger,
  input  wire logic                  receive_data_in
);
  localparam int unsigned FB = sar_pkg::FRAME_BITS;
  localparam int unsigned LW = $clog2(FIFO_DEPTH) + 1;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic                en_reg;
  logic                hold_reg;
  logic [7:0]          div_reg;
  logic [7:0]          per_reg;
  logic                ovf_reg;
  logic [7:0]          wrap_reg;
  logic [IW-1:0]       raddr_reg;
  logic [IW-1:0]       widx_reg;
  logic [FB-1:0]       last_reg;
  logic [31:0]         rdata_reg;
  sar_pkg::sar_state_t state_reg;

  wire       wr_ctrl  = bus_req.wr && bus_req.addr == sar_pkg::OFS_CTRL;
  wire       wr_div   = bus_req.wr && bus_req.addr == sar_pkg::OFS_DIV;
  wire       wr_per   = bus_req.wr && bus_req.addr == sar_pkg::OFS_PER;
  wire       wr_stat  = bus_req.wr && bus_req.addr == sar_pkg::OFS_STAT;
  wire       wr_raddr = bus_req.wr && bus_req.addr == sar_pkg::OFS_RADDR;
  wire       sw_flush = wr_ctrl && bus_req.wdata[sar_pkg::CTRL_FLUSH];
  wire       ovf_clr  = wr_stat && bus_req.wdata[sar_pkg::STAT_OVF];
  wire       running  = (state_reg == sar_pkg::SAR_RUN);
  // divider and period are locked while the port runs
  wire       cfg_ok   = !en_reg;
  wire [7:0] div_eff  = (div_reg < sar_pkg::DIV_MIN) ?
                        sar_pkg::DIV_MIN : div_reg;
  wire [7:0] per_eff  = (per_reg < 8'(FB)) ? 8'(FB) : per_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_reg    <= 1'b0;
      hold_reg  <= 1'b0;
      div_reg   <= sar_pkg::DIV_RST;
      per_reg   <= sar_pkg::PER_RST;
      raddr_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        en_reg   <= bus_req.wdata[sar_pkg::CTRL_EN];
        hold_reg <= bus_req.wdata[sar_pkg::CTRL_HOLD];
      end
      if (wr_div && cfg_ok)
        div_reg <= bus_req.wdata[7:0];
      if (wr_per && cfg_ok)
        per_reg <= bus_req.wdata[7:0];
      if (wr_raddr)
        raddr_reg <= bus_req.wdata[IW-1:0];
    end
  end

  cfg_lock_a: assert property (
    @(posedge clk) disable iff (rst)
    en_reg && (wr_div || wr_per) |=>
      $stable(div_reg) && $stable(per_reg))
    else $error("divider or period changed while running");

  // ----------------------------------------------------------------
  // serial clock and frame sync generation
  // ----------------------------------------------------------------
  logic [7:0] div_cnt_reg;
  logic [7:0] bit_cnt_reg;
  logic       sclk_reg;
  logic       fs_reg;

  wire [7:0] half_cnt = {1'b0, div_eff[7:1]};
  // fall: a new bit period starts; rise: the bit is sampled
  wire       fall_evt = running && div_cnt_reg == div_eff - 8'h01;
  wire       rise_evt = running && div_cnt_reg == half_cnt - 8'h01;
  wire       last_bit = bit_cnt_reg >= per_eff - 8'h01;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg   <= sar_pkg::SAR_IDLE;
      div_cnt_reg <= 8'h00;
      bit_cnt_reg <= 8'h00;
      sclk_reg    <= 1'b0;
      fs_reg      <= 1'b0;
    end else if (!en_reg) begin
      // parked so the first running cycle opens frame bit 0
      state_reg   <= sar_pkg::SAR_IDLE;
      div_cnt_reg <= div_eff - 8'h01;
      bit_cnt_reg <= per_eff - 8'h01;
      sclk_reg    <= 1'b0;
      fs_reg      <= 1'b0;
    end else begin
      state_reg <= sar_pkg::SAR_RUN;
      if (running) begin
        div_cnt_reg <= fall_evt ? 8'h00 : div_cnt_reg + 8'h01;
        if (fall_evt) begin
          sclk_reg    <= 1'b0;
          bit_cnt_reg <= last_bit ? 8'h00 : bit_cnt_reg + 8'h01;
          fs_reg      <= last_bit;
        end else if (rise_evt) begin
          sclk_reg <= 1'b1;
        end
      end
    end
  end

  // one registered pulse feeds both read strobe and conversion start
  assign serial_clock_out   = sclk_reg;
  assign frame_sync_out     = fs_reg;
  assign conversion_trigger = fs_reg;

  sclk_fall_a: assert property (
    @(posedge clk) disable iff (rst)
    fall_evt && en_reg |=> !sclk_reg && div_cnt_reg == 8'h00)
    else $error("serial clock period differs from divider");

  sclk_rise_a: assert property (
    @(posedge clk) disable iff (rst)
    running && en_reg && rise_evt |=> sclk_reg ##1 !fall_evt || !sclk_reg)
    else $error("serial clock failed to rise");

  fs_period_a: assert property (
    @(posedge clk) disable iff (rst)
    en_reg && fall_evt && last_bit |=> fs_reg && bit_cnt_reg == 8'h00)
    else $error("frame sync missed its period");

  fs_width_a: assert property (
    @(posedge clk) disable iff (rst)
    fs_reg && fall_evt && en_reg |=> !fs_reg)
    else $error("frame sync wider than one serial clock");

  fs_start_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(conversion_trigger) |-> bit_cnt_reg == 8'h00 && !sclk_reg)
    else $error("conversion start off frame start");

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  logic          din_meta_reg;
  logic          din_reg;
  logic [FB-1:0] sh_reg;
  logic          push_reg;
  logic [FB-1:0] push_word_reg;
  logic          fifo_in_ready;

  // capture from bit 0, the sync bit itself: zero data delay
  wire           cap_bit  = rise_evt && bit_cnt_reg < 8'(FB);
  wire           cap_last = rise_evt && bit_cnt_reg == 8'(FB - 1);
  wire [FB-1:0]  sh_next  = {sh_reg[FB-2:0], din_reg};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      din_meta_reg  <= 1'b0;
      din_reg       <= 1'b0;
      sh_reg        <= '0;
      push_reg      <= 1'b0;
      push_word_reg <= '0;
    end else begin
      din_meta_reg <= receive_data_in;
      din_reg      <= din_meta_reg;
      push_reg     <= cap_last;
      if (cap_bit)
        sh_reg <= sh_next;
      if (cap_last)
        push_word_reg <= sh_next;
    end
  end

  word_push_a: assert property (
    @(posedge clk) disable iff (rst)
    cap_last |=> push_reg && push_word_reg == $past(sh_next))
    else $error("twentieth bit did not complete a word");

  // ----------------------------------------------------------------
  // fifo and circular sample buffer
  // ----------------------------------------------------------------
  logic          fifo_out_valid;
  logic [FB-1:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic [sar_pkg::RES_BITS-1:0] buf_reg [BUF_DEPTH];

  // hold lets software read a stable buffer; the fifo then absorbs
  wire take     = fifo_out_valid && running && !hold_reg;
  wire wrap_now = take && widx_reg == IW'(BUF_DEPTH - 1);
  wire flush    = sw_flush || wrap_now;
  wire dropped  = push_reg && !fifo_in_ready;
  wire [sar_pkg::RES_BITS-1:0] result =
    fifo_out_data[sar_pkg::RES_LSB +: sar_pkg::RES_BITS];

  sar_fifo #(
    .W  (FB),
    .D  (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (flush),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word_reg),
    .out_valid (fifo_out_valid),
    .out_ready (take),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      widx_reg <= '0;
      wrap_reg <= 8'h00;
      ovf_reg  <= 1'b0;
      last_reg <= '0;
    end else begin
      if (wrap_now) begin
        widx_reg <= '0;
        wrap_reg <= wrap_reg + 8'h01;
      end else if (take) begin
        widx_reg <= widx_reg + 1'b1;
      end
      if (take)
        last_reg <= fifo_out_data;
      // a new drop wins over a clear in the same cycle
      if (dropped)
        ovf_reg <= 1'b1;
      else if (ovf_clr)
        ovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (take)
      buf_reg[widx_reg] <= result;
  end

  buf_step_a: assert property (
    @(posedge clk) disable iff (rst)
    take && !wrap_now |=> widx_reg == $past(widx_reg) + 1'b1)
    else $error("write index did not advance");

  buf_wrap_a: assert property (
    @(posedge clk) disable iff (rst)
    wrap_now |=> widx_reg == '0 && fifo_level == '0)
    else $error("full buffer not rewound and flushed");

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  wire [31:0] stat_word = {wrap_reg, 3'h0, 5'(fifo_level), 4'h0,
                           ovf_reg, 1'b0, 10'(widx_reg)};
  wire [31:0] rd_mux =
    bus_req.addr == sar_pkg::OFS_CTRL  ?
      {29'h0, hold_reg, 1'b0, en_reg} :
    bus_req.addr == sar_pkg::OFS_DIV   ? {24'h0, div_reg} :
    bus_req.addr == sar_pkg::OFS_PER   ? {24'h0, per_reg} :
    bus_req.addr == sar_pkg::OFS_STAT  ? stat_word :
    bus_req.addr == sar_pkg::OFS_RADDR ? 32'(raddr_reg) :
    bus_req.addr == sar_pkg::OFS_RDATA ? 32'(buf_reg[raddr_reg]) :
    bus_req.addr == sar_pkg::OFS_LAST  ? 32'(last_reg) :
    32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= bus_req.rd ? rd_mux : 32'h0000_0000;
  end

  assign bus_rdata = rdata_reg;

  ovf_sticky_a: assert property (
    @(posedge clk) disable iff (rst)
    dropped |=> ovf_reg)
    else $error("dropped frame not flagged");
endmodule

// ### sar_conv_model.sv
// sar_conv_model: behavioural serial converter at the reader's far side.
// assumes the reader's system clock; frame sync is read and start strobe.
`timescale 1ns/100ps
module sar_conv_model (
  input  wire logic        clk,
  input  wire logic        serial_clock_out,
  input  wire logic        frame_sync_out,
  input  wire logic        conversion_trigger,
  input  wire logic [15:0] next_value,
  output      logic        receive_data_in
);
  // --------------------------------------------------------------
  // conversion and shift out
  // --------------------------------------------------------------
  // single converter: select is tied active, nothing to sequence
  logic [15:0] shift_reg = 16'h0;
  logic [4:0]  bit_cnt   = 5'h0f;
  logic        sclk_d    = 1'b0;
  logic        start_d   = 1'b0;
  wire         start     = frame_sync_out && conversion_trigger;
  initial receive_data_in = 1'b0;
  always @(posedge clk) begin
    sclk_d  <= serial_clock_out;
    start_d <= start;
    if (start && !start_d) begin
      shift_reg       <= next_value;
      bit_cnt         <= 5'h00;
      receive_data_in <= next_value[15];
    end else if (sclk_d && !serial_clock_out) begin
      if (bit_cnt < 5'h0f) begin
        shift_reg       <= {shift_reg[14:0], 1'b0};
        bit_cnt         <= bit_cnt + 5'h01;
        receive_data_in <= shift_reg[14];
      end else begin
        // result done: the line is not held, so keep it moving
        receive_data_in <= ~receive_data_in;
      end
    end
  end
endmodule

// ### sar_reader_bench.sv
// sar_reader_bench: self-checking bench of the converter reader.
// assumes the package, design and converter model are compiled first.
`timescale 1ns/100ps
module sar_reader_bench;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  localparam int BUF = 8;
  logic                  clk        = 1'b0;
  logic                  rst        = 1'b1;
  sar_pkg::sar_bus_req_t bus_req    = '0;
  logic [31:0]           bus_rdata;
  logic                  serial_clock_out;
  logic                  frame_sync_out;
  logic                  conversion_trigger;
  logic                  receive_data_in;
  logic [15:0]           next_value = 16'h0;
  logic [15:0]           sent_q[$];
  logic                  fs_seen    = 1'b0;
  logic [31:0]           rv;
  int                    errors     = 0;
  int                    cmp_count  = 0;
  int                    frames     = 0;
  int                    d, p, i0, w0, n;

  always #25 clk = ~clk;

  // short buffer so that a wrap fits in the run
  sar_reader #(.BUF_DEPTH(BUF), .FIFO_DEPTH(16)) dut (
    .clk(clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .serial_clock_out(serial_clock_out), .frame_sync_out(frame_sync_out),
    .conversion_trigger(conversion_trigger),
    .receive_data_in(receive_data_in));
  // one converter on the port: its select is tied active, none driven
  sar_conv_model conv (
    .clk(clk), .serial_clock_out(serial_clock_out),
    .frame_sync_out(frame_sync_out),
    .conversion_trigger(conversion_trigger), .next_value(next_value),
    .receive_data_in(receive_data_in));

  // record each converted value; change it only once the model latched it
  always @(negedge clk) begin
    if (frame_sync_out && !fs_seen) begin
      sent_q.push_back(next_value);
      frames++;
    end
    if (!frame_sync_out && fs_seen) next_value <= 16'($urandom);
    fs_seen <= frame_sync_out;
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e, input string nm);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    rv = bus_rdata;
    check(nm, rv & m, e);
  endtask

  task automatic wait_frames(input int k);
    int target;
    target = frames + k;
    for (int c = 0; c < k * 3000; c++) begin
      @(negedge clk);
      if (frames >= target) return;
    end
    errors++;
    $display("BAD frame wait expected %0d seen %0d", target, frames);
    stop_test();
  endtask

  // one frame from sync rise to sync rise, counted cycle by cycle
  task automatic meas(input int dv, input int pv);
    int h, t, r, hi;
    logic ps, pf;
    h = 0; t = 0; r = 0; hi = 0; pf = 1'b1;
    for (int c = 0; c < 5000 && !(frame_sync_out && !pf); c++) begin
      pf = frame_sync_out;
      @(negedge clk);
    end
    ps = serial_clock_out;
    pf = 1'b1;
    for (int c = 0; c < 5000 && !(frame_sync_out && !pf); c++) begin
      check("trigger", conversion_trigger, frame_sync_out);
      h  += frame_sync_out;
      hi += serial_clock_out;
      r  += (serial_clock_out && !ps);
      ps = serial_clock_out;
      pf = frame_sync_out;
      t++;
      @(negedge clk);
    end
    check("sync width", h, dv);
    check("frame length", t, pv * dv);
    check("sclk rises", r, pv);
    check("sclk high", hi, pv * (dv - dv / 2));
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(63));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(sar_pkg::OFS_CTRL, '1, 32'h0, "ctrl reset");
    rdchk(sar_pkg::OFS_DIV, 32'hff, 32'h10, "div reset");
    rdchk(sar_pkg::OFS_PER, 32'hff, 32'h14, "per reset");
    rdchk(sar_pkg::OFS_STAT, '1, 32'h0, "stat reset");
    rdchk(8'h1c, '1, 32'h0, "unmapped");
    repeat (40) begin
      @(negedge clk);
      check("idle pins", {serial_clock_out, frame_sync_out}, 0);
    end
    // random divider and period, locked once running
    d = 8 + $urandom_range(12);
    p = 20 + $urandom_range(4);
    wr(sar_pkg::OFS_DIV, 32'(d));
    wr(sar_pkg::OFS_PER, 32'(p));
    wr(sar_pkg::OFS_CTRL, 32'h1);
    wr(sar_pkg::OFS_DIV, 32'h2);
    rdchk(sar_pkg::OFS_DIV, 32'hff, 32'(d), "div lock");
    meas(d, p);
    meas(d, p);
    wr(sar_pkg::OFS_CTRL, 32'h0);
    // data path at divider 8, period 20
    wr(sar_pkg::OFS_DIV, 32'h8);
    wr(sar_pkg::OFS_PER, 32'h14);
    repeat (10) @(posedge clk);
    rdchk(sar_pkg::OFS_STAT, 32'h001f0800, 32'h0, "stat snap");
    i0 = int'(rv[9:0]);
    w0 = int'(rv[31:24]);
    sent_q.delete();
    wr(sar_pkg::OFS_CTRL, 32'h1);
    wait_frames(6);
    rdchk(sar_pkg::OFS_STAT, 32'h3ff, 32'((i0 + 5) % BUF), "index");
    for (int k = 0; k < 5; k++) begin
      wr(sar_pkg::OFS_RADDR, 32'((i0 + k) % BUF));
      rdchk(sar_pkg::OFS_RDATA, 32'hffff, {16'h0, sent_q[k]}, "sample");
    end
    rdchk(sar_pkg::OFS_LAST, 32'hffff0, {12'h0, sent_q[4], 4'h0}, "last");
    // run past the end of the buffer
    wait_frames(BUF);
    n = i0 + 13;
    rdchk(sar_pkg::OFS_STAT, 32'hff0003ff,
          {8'(w0 + n / BUF), 14'h0, 10'(n % BUF)}, "wrap");
    wr(sar_pkg::OFS_RADDR, 32'((n - 1) % BUF));
    rdchk(sar_pkg::OFS_RDATA, 32'hffff, {16'h0, sent_q[12]}, "refill");
    // stall the buffer until the fifo refuses, then drain it
    wr(sar_pkg::OFS_CTRL, 32'h5);
    wait_frames(18);
    rdchk(sar_pkg::OFS_STAT, 32'h001f0800, 32'h00100800, "fifo full");
    wr(sar_pkg::OFS_CTRL, 32'h1);
    repeat (30) @(posedge clk);
    wr(sar_pkg::OFS_STAT, 32'h800);
    rdchk(sar_pkg::OFS_STAT, 32'h001f0800, 32'h0, "fifo drained");
    // hold a few words, then drop them with a software flush
    wr(sar_pkg::OFS_CTRL, 32'h5);
    wait_frames(3);
    rdchk(sar_pkg::OFS_STAT, 32'h001f0000, 32'h00030000, "held");
    wr(sar_pkg::OFS_CTRL, 32'h7);
    rdchk(sar_pkg::OFS_STAT, 32'h001f0000, 32'h0, "flush");
    rdchk(sar_pkg::OFS_CTRL, '1, 32'h5, "flush clears");
    stop_test();
  end
endmodule
